// file: include/rts_regs.vh
// register map, field positions, reset values and time figures of the
// recloser test sequencer; included by the sequencer design file and the bench, not by the timebase
`ifndef RTS_REGS_VH
`define RTS_REGS_VH
// byte addresses on the AXI4-Lite slave
`define RTS_A_CTRL   8'h00
`define RTS_A_SEL    8'h04
`define RTS_A_SHOT   8'h08
`define RTS_A_AUX    8'h0c
`define RTS_A_SCALE  8'h10
`define RTS_A_STAT   8'h14
`define RTS_A_FAULT  8'h18
// control bits; read, test and clear are write-one pulses
`define RTS_C_READ   0
`define RTS_C_TEST   1
`define RTS_C_DELAY  2
`define RTS_C_EN     3
`define RTS_C_FCLR   4
// writable masks, reserved bits read zero
`define RTS_M_CTRL   32'h0000000c
`define RTS_M_SEL    32'h0000003f
`define RTS_M_SHOT   32'h00ffffff
`define RTS_M_AUX    32'hffffffff
`define RTS_M_SCALE  32'h0000000f
`define RTS_SCALE_RST 32'h00000001
// responses
`define RTS_RESP_OK  2'b00
`define RTS_RESP_DEC 2'b11
// time figures
`define RTS_CLK_NS   50
`define RTS_TICK_MS  500
`define RTS_PULSE_MS 900
`define RTS_HOUR_S   3600
`define RTS_HOLD_LAST 3'h7
`define RTS_NORM_HOLD 12'h002
`define RTS_RST_LIMIT 2'h2
`define RTS_FAIL_WDOG 8'h01
`endif

// file: rtl/rts_tick.v
// half-second timebase: one-cycle tick and a blink level toggling per tick
// assumes a free clock and a clock enable that freezes the count
`timescale 1ns/10ps
module rts_tick #(
   parameter [23:0] TICK_CYC = 24'd10000000
) (
   input  wire aclk,
   input  wire aresetn,
   input  wire ce,
   output reg  tick,
   output reg  blink
);
   reg [23:0] cnt_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 24'h000000;
         tick  <= 1'b0;
         blink <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (cnt_r == TICK_CYC - 24'h000001) begin
            cnt_r <= 24'h000000;
            tick  <= 1'b1;
            blink <= ~blink;
         end else begin
            cnt_r <= cnt_r + 24'h000001;
         end
      end
   end
endmodule

// file: rtl/rts_sequencer.v
// recloser settings read-out, built-in test and restart supervision
// assumes an AXI4-Lite master on aclk; contacts and switch are asynchronous
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
`include "rts_regs.vh"
module rts_sequencer #(
   parameter [23:0] TICK_CYC   = `RTS_TICK_MS * 1000000 / `RTS_CLK_NS,
   parameter [24:0] PULSE_CYC  = `RTS_PULSE_MS * 1000000 / `RTS_CLK_NS,
   parameter [12:0] HOUR_TICKS = `RTS_HOUR_S * 1000 / `RTS_TICK_MS
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   input  wire        breaker_closed_contact,
   input  wire        breaker_open_contact,
   input  wire        delayed_first_shot_input,
   input  wire        mode_select_switch,
   input  wire        watchdog_restart,
   output reg         shot_pending_lamp,
   output reg         rearm_lamp,
   output reg         inst_lamp,
   output reg         lockout_lamp,
   output reg         pause_lamp,
   output reg         spare_lamp,
   output reg         pu_do_lamp,
   output reg  [3:0]  shot_num_lamps,
   output reg  [15:0] disp_value,
   output reg         relays_frozen,
   output reg  [7:0]  fail_code
);
   localparam [6:0] S_IDLE = 7'h01, S_NORM = 7'h02, S_SH1 = 7'h04, S_SH2 = 7'h08;
   localparam [6:0] S_SH3 = 7'h10, S_LOCK = 7'h20, S_REARM = 7'h40;

   function [11:0] scl;
      input [7:0] t;
      input [3:0] m;
      scl = t * m;
   endfunction

   // smallest selected timed shot above position p, zero means none left
   function [1:0] nxt_shot;
      input [3:0] s;
      input [1:0] p;
      integer i;
      begin
         nxt_shot = 2'h0;
         for (i = 3; i >= 1; i = i - 1)
            if (i > p && s[i])
               nxt_shot = i[1:0];
      end
   endfunction

   function [3:0] nxt_step;
      input [2:0] cur;
      input [7:0] used;
      integer i;
      begin
         nxt_step = 4'h8;
         for (i = 7; i >= 0; i = i - 1)
            if (i > cur && used[i])
               nxt_step = i[3:0];
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] d;
      input [3:0]  be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = d[i*8 +: 8];
      end
   endfunction

   function dec_ok;
      input [7:0] a;
      dec_ok = (a == `RTS_A_CTRL) || (a == `RTS_A_SEL) || (a == `RTS_A_SHOT) ||
               (a == `RTS_A_AUX) || (a == `RTS_A_SCALE) || (a == `RTS_A_STAT) ||
               (a == `RTS_A_FAULT);
   endfunction

   // -------------------------------------------------------------
   // timebase and pin synchronisers
   // -------------------------------------------------------------
   wire tick;
   wire blink;
   rts_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .tick    (tick),
      .blink   (blink)
   );

   wire [3:0] pins = {mode_select_switch, delayed_first_shot_input,
                      breaker_open_contact, breaker_closed_contact};
   reg  [3:0] s1_r, s2_r, s3_r, pin_r;
   reg  [4:0] arm_r;
   reg        sw_prev_r;
   wire [3:0] agree = ~(s2_r ^ s3_r);
   // switch watching starts only once the filter holds real samples
   wire       sw_chg = arm_r[4] & (pin_r[3] ^ sw_prev_r);
   wire       brk_closed = pin_r[0] & ~pin_r[1];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         pin_r <= 4'h0;
         arm_r <= 5'h00;
         sw_prev_r <= 1'b0;
      end else if (ce) begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (pin_r & ~agree) | (s3_r & agree);
         arm_r <= {arm_r[3:0], 1'b1};
         sw_prev_r <= pin_r[3];
      end
   end

   // -------------------------------------------------------------
   // register file
   // -------------------------------------------------------------
   reg  [31:0] ctrl_r, sel_r, shot_r, aux_r, scale_r;
   reg  [6:0]  st_r;
   reg         rd_act_r;
   wire        wr_go = ce & awvalid & wvalid & ~bvalid;
   wire        rd_go = ce & arvalid & ~rvalid;
   wire        wr_ctrl = wr_go & (awaddr == `RTS_A_CTRL) & wstrb[0];
   wire        idle = (st_r == S_IDLE) & ~rd_act_r;
   wire        go_test = wr_ctrl & wdata[`RTS_C_TEST] & ctrl_r[`RTS_C_EN] & idle;
   wire        go_rd = wr_ctrl & wdata[`RTS_C_READ] & idle;
   wire        fclr = wr_ctrl & wdata[`RTS_C_FCLR];
   wire [3:0]  time_scale_factor = scale_r[3:0];
   wire [3:0]  sel = sel_r[3:0];
   wire [1:0]  spare_sel = sel_r[5:4];
   reg  [31:0] rmux;

   assign awready = wr_go;
   assign wready  = wr_go;
   assign arready = rd_go;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 32'h00000000;
         sel_r <= 32'h00000000;
         shot_r <= 32'h00000000;
         aux_r <= 32'h00000000;
         scale_r <= `RTS_SCALE_RST;
         bvalid <= 1'b0;
         bresp <= `RTS_RESP_OK;
      end else if (ce) begin
         if (bvalid && bready)
            bvalid <= 1'b0;
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= dec_ok(awaddr) ? `RTS_RESP_OK : `RTS_RESP_DEC;
            case (awaddr)
               `RTS_A_CTRL:  ctrl_r <= merge(ctrl_r, wdata, wstrb) & `RTS_M_CTRL;
               `RTS_A_SEL:   sel_r <= merge(sel_r, wdata, wstrb) & `RTS_M_SEL;
               `RTS_A_SHOT:  shot_r <= merge(shot_r, wdata, wstrb) & `RTS_M_SHOT;
               `RTS_A_AUX:   aux_r <= merge(aux_r, wdata, wstrb) & `RTS_M_AUX;
               `RTS_A_SCALE: scale_r <= merge(scale_r, wdata, wstrb) & `RTS_M_SCALE;
               default: ;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // built-in test sequence
   // -------------------------------------------------------------
   reg  [11:0] cnt_r;
   reg  [3:0]  sel_run_r;
   reg         pass_r, lockst_r;
   reg  [6:0]  adv_st;
   reg  [11:0] adv_cnt;
   wire        expd = tick & (cnt_r == 12'h000);
   wire [1:0]  pos = (st_r == S_SH1) ? 2'h1 : (st_r == S_SH2) ? 2'h2 :
                     (st_r == S_SH3) ? 2'h3 : 2'h0;
   wire        norm_go = (st_r == S_NORM) & expd & ~(pass_r & ~lockst_r);
   wire        fire = (expd & (pos != 2'h0)) | (norm_go & sel_run_r[0]);

   always @* begin
      case (nxt_shot(sel_run_r, pos))
         2'h1: begin
            adv_st = S_SH1;
            adv_cnt = scl(shot_r[7:0], time_scale_factor);
         end
         2'h2: begin
            adv_st = S_SH2;
            adv_cnt = scl(shot_r[15:8], time_scale_factor);
         end
         2'h3: begin
            adv_st = S_SH3;
            adv_cnt = scl(shot_r[23:16], time_scale_factor);
         end
         default: begin
            adv_st = S_LOCK;
            adv_cnt = `RTS_NORM_HOLD;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= S_IDLE;
         cnt_r <= 12'h000;
         sel_run_r <= 4'h0;
         pass_r <= 1'b0;
         lockst_r <= 1'b0;
      end else if (ce) begin
         if (tick && cnt_r != 12'h000)
            cnt_r <= cnt_r - 12'h001;
         case (st_r)
            S_IDLE: if (go_test) begin
               pass_r <= 1'b0;
               lockst_r <= ~brk_closed;
               sel_run_r <= (ctrl_r[`RTS_C_DELAY] | pin_r[2]) ? (sel & (sel - 4'h1)) : sel;
               st_r <= brk_closed ? S_NORM : S_LOCK;
               cnt_r <= `RTS_NORM_HOLD;
            end
            S_NORM: if (expd) begin
               if (pass_r && !lockst_r) begin
                  st_r <= S_IDLE;
               end else begin
                  st_r <= adv_st;
                  cnt_r <= adv_cnt;
               end
            end
            S_SH1, S_SH2, S_SH3: if (expd) begin
               st_r <= adv_st;
               cnt_r <= adv_cnt;
            end
            S_LOCK: if (expd) begin
               if (pass_r && lockst_r) begin
                  st_r <= S_IDLE;
               end else begin
                  st_r <= S_REARM;
                  cnt_r <= scl(aux_r[7:0], time_scale_factor);
               end
            end
            S_REARM: if (expd) begin
               pass_r <= 1'b1;
               st_r <= S_NORM;
               cnt_r <= `RTS_NORM_HOLD;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // spare output timing and reclose indication pulse
   // -------------------------------------------------------------
   reg        sp_pu_r, sp_do_r, pulse_r;
   reg [11:0] sp_cnt_r;
   reg [24:0] pcnt_r;
   reg [3:0]  prep_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         sp_pu_r <= 1'b0;
         sp_do_r <= 1'b0;
         sp_cnt_r <= 12'h000;
         pulse_r <= 1'b0;
         pcnt_r <= 25'h0000000;
         prep_r <= 4'h0;
      end else if (ce) begin
         if (tick && sp_cnt_r != 12'h000)
            sp_cnt_r <= sp_cnt_r - 12'h001;
         if (tick && sp_cnt_r == 12'h000) begin
            sp_pu_r <= 1'b0;
            sp_do_r <= sp_pu_r;
            if (sp_pu_r)
               sp_cnt_r <= scl(aux_r[31:24], time_scale_factor);
         end
         if (fire && pos == spare_sel) begin
            sp_pu_r <= 1'b1;
            sp_do_r <= 1'b0;
            sp_cnt_r <= scl(aux_r[23:16], time_scale_factor);
         end
         // 0.9 s per unit of multiplier
         if (pulse_r) begin
            if (pcnt_r != 25'h0000000) begin
               pcnt_r <= pcnt_r - 25'h0000001;
            end else if (prep_r > 4'h1) begin
               prep_r <= prep_r - 4'h1;
               pcnt_r <= PULSE_CYC - 25'h0000001;
            end else begin
               pulse_r <= 1'b0;
            end
         end
         if (fire) begin
            pulse_r <= 1'b1;
            pcnt_r <= PULSE_CYC - 25'h0000001;
            prep_r <= time_scale_factor;
         end
      end
   end

   // -------------------------------------------------------------
   // settings read-out
   // -------------------------------------------------------------
   reg  [2:0] step_r, hold_r;
   wire [7:0] used = {{2{|aux_r[31:16]}}, |aux_r[15:8], 1'b1, sel[3:1], 1'b1};
   wire [3:0] nstep = nxt_step(step_r, used);

   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_act_r <= 1'b0;
         step_r <= 3'h0;
         hold_r <= 3'h0;
      end else if (ce) begin
         if (go_rd) begin
            rd_act_r <= 1'b1;
            step_r <= 3'h0;
            hold_r <= 3'h0;
         end else if (rd_act_r && tick) begin
            hold_r <= hold_r + 3'h1;
            if (hold_r == `RTS_HOLD_LAST) begin
               rd_act_r <= ~nstep[3];
               step_r <= nstep[2:0];
            end
         end
      end
   end

   // -------------------------------------------------------------
   // lamps and display
   // -------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         {shot_pending_lamp, rearm_lamp, inst_lamp, lockout_lamp} <= 4'h0;
         {pause_lamp, spare_lamp, pu_do_lamp, relays_frozen} <= 4'h0;
         shot_num_lamps <= 4'h0;
         disp_value <= 16'h0000;
      end else if (ce) begin
         // relays held, lamp alone shows reclose
         relays_frozen <= (st_r != S_IDLE);
         shot_pending_lamp <= pulse_r;
         {rearm_lamp, inst_lamp, lockout_lamp, pause_lamp, pu_do_lamp} <= 5'h00;
         spare_lamp <= sp_do_r & blink;
         shot_num_lamps <= 4'h0;
         disp_value <= {4'h0, (pos == 2'h1) ? cnt_r : {1'b0, cnt_r[11:1]}};
         if (rd_act_r) begin
            disp_value <= 16'h0000;
            case (step_r)
               3'h0: begin
                  shot_num_lamps <= sel;
                  shot_pending_lamp <= blink;
               end
               3'h1, 3'h2, 3'h3: begin
                  shot_num_lamps <= 4'h1 << step_r;
                  disp_value <= {8'h00, shot_r[(step_r - 3'h1) * 8 +: 8]};
                  shot_pending_lamp <= blink;
               end
               3'h4: begin
                  disp_value <= {8'h00, aux_r[7:0]};
                  rearm_lamp <= blink;
               end
               3'h5: begin
                  disp_value <= {8'h00, aux_r[15:8]};
                  pause_lamp <= blink;
               end
               3'h6: begin
                  disp_value <= aux_r[31:16];
                  spare_lamp <= blink;
                  pu_do_lamp <= blink;
               end
               default: begin
                  disp_value <= {14'h0000, spare_sel};
                  spare_lamp <= blink;
               end
            endcase
         end else begin
            case (st_r)
               S_NORM: rearm_lamp <= 1'b1;
               S_SH1: begin
                  shot_pending_lamp <= blink | pulse_r;
                  inst_lamp <= sel_run_r[0] & blink;
               end
               S_SH2, S_SH3: begin
                  shot_pending_lamp <= blink | pulse_r;
                  inst_lamp <= blink;
               end
               S_LOCK: {inst_lamp, lockout_lamp} <= {2{blink}};
               S_REARM: {rearm_lamp, inst_lamp, lockout_lamp} <= {3{blink}};
               default: ;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // restart supervision and read port
   // -------------------------------------------------------------
   reg [1:0]  rcnt_r;
   reg [12:0] hour_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rcnt_r <= 2'h0;
         hour_r <= 13'h0000;
         fail_code <= 8'h00;
      end else if (ce) begin
         if (tick && rcnt_r != 2'h0) begin
            hour_r <= hour_r + 13'h0001;
            if (hour_r == HOUR_TICKS - 13'h0001)
               rcnt_r <= 2'h0;
         end
         if (fclr)
            fail_code <= 8'h00;
         if (sw_chg) begin
            if (rcnt_r == 2'h0)
               hour_r <= 13'h0000;
            rcnt_r <= rcnt_r + 2'h1;
            // third restart in the hour fails
            if (rcnt_r == `RTS_RST_LIMIT) begin
               rcnt_r <= 2'h0;
               fail_code <= `RTS_FAIL_WDOG;
            end
         end
         if (watchdog_restart)
            fail_code <= `RTS_FAIL_WDOG;
      end
   end

   always @* begin
      case (araddr)
         `RTS_A_CTRL:  rmux = ctrl_r;
         `RTS_A_SEL:   rmux = sel_r;
         `RTS_A_SHOT:  rmux = shot_r;
         `RTS_A_AUX:   rmux = aux_r;
         `RTS_A_SCALE: rmux = scale_r;
         `RTS_A_STAT:  rmux = {8'h00, cnt_r, sp_do_r, step_r, rd_act_r, st_r};
         `RTS_A_FAULT: rmux = {22'h000000, rcnt_r, fail_code};
         default:      rmux = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RTS_RESP_OK;
      end else if (ce) begin
         if (rvalid && rready)
            rvalid <= 1'b0;
         if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rmux;
            rresp <= dec_ok(araddr) ? `RTS_RESP_OK : `RTS_RESP_DEC;
         end
      end
   end
endmodule

// file: verification/rts_sequencer_assertions.sv
// port checker of the recloser test sequencer
// assumes binding onto rts_sequencer, one clock, sync active-low reset
`timescale 1ns/10ps
module rts_sequencer_assertions #(
   parameter [24:0] PULSE_CYC = 25'd4
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        ce,
   input wire        awvalid,
   input wire        wvalid,
   input wire        awready,
   input wire        bvalid,
   input wire        arvalid,
   input wire        arready,
   input wire        rvalid,
   input wire        rready,
   input wire [31:0] rdata,
   input wire        watchdog_restart,
   input wire        shot_pending_lamp,
   input wire        lockout_lamp,
   input wire        relays_frozen,
   input wire [15:0] disp_value,
   input wire [7:0]  fail_code
);
   // ----------------
   // helper and rules
   // ----------------
   reg [24:0] plen_r;
   // lamp on-time counter; the lamp also blinks, so only a floor is checked
   always @(posedge aclk) begin
      plen_r <= shot_pending_lamp ? plen_r + 25'd1 : 25'd0;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      awvalid && wvalid && awready;
   endsequence
   sequence s_rtake;
      arvalid && arready;
   endsequence
   a_write_answer: assert property (s_wtake |=> bvalid)
      else $error("write not answered");
   a_busy_refuse: assert property (bvalid |-> !awready)
      else $error("write taken while answer pending");
   a_read_answer: assert property (s_rtake |=> rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   a_wdog_code: assert property (watchdog_restart |=> fail_code == 8'h01)
      else $error("watchdog restart code missing");
   a_fail_value: assert property (fail_code != 8'h00 |-> fail_code == 8'h01)
      else $error("unexpected failure code");
   a_lockout_frozen: assert property (lockout_lamp |-> relays_frozen)
      else $error("lockout shown outside test");
   a_pulse_length: assert property ($fell(shot_pending_lamp) && relays_frozen
      && $past(aresetn) |-> plen_r >= PULSE_CYC)
      else $error("reclose indication too short");
   a_freeze_hold: assert property (!ce |=> $stable(disp_value) && $stable(lockout_lamp))
      else $error("state moved while frozen");
endmodule
bind rts_sequencer rts_sequencer_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .wvalid(wvalid),
   .awready(awready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .watchdog_restart(watchdog_restart),
   .shot_pending_lamp(shot_pending_lamp), .lockout_lamp(lockout_lamp),
   .relays_frozen(relays_frozen), .disp_value(disp_value), .fail_code(fail_code));

// file: verification/rts_breaker_model.sv
// breaker status contacts of the far side
// assumes a close command from the bench, changed after a clock edge
`timescale 1ns/10ps
module rts_breaker_model (
   input  wire aclk,
   input  wire close_cmd,
   output wire breaker_closed_contact,
   output wire breaker_open_contact
);
   reg       pos_r = 1'b0;
   reg [2:0] cnt_r = 3'h0;
   // seven cycles of travel with neither contact made, as a real mechanism
   always @(posedge aclk) begin
      cnt_r <= (close_cmd != pos_r) ? cnt_r + 3'h1 : 3'h0;
      if (cnt_r == 3'h6) begin
         pos_r <= close_cmd;
      end
   end
   assign breaker_closed_contact = pos_r && cnt_r == 3'h0;
   assign breaker_open_contact   = !pos_r && cnt_r == 3'h0;
endmodule

// file: verification/tb_top.sv
// self-checking bench of the recloser test sequencer
// assumes the design shortened to a 10-cycle tick and a 4-cycle pulse
`timescale 1ns/10ps
`include "rts_regs.vh"
module tb_top;
   reg         aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
   reg         bready = 1'b0, arvalid = 1'b0, rready = 1'b0, close_cmd = 1'b1, dly_in = 1'b0;
   reg         mode_sw = 1'b0, wdog = 1'b0, fq = 1'b0, fin = 1'b0;
   reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg  [31:0] wdata = 32'h0, v, d;
   reg  [3:0]  wstrb = 4'hf;
   reg  [33:0] m, eq[$], mq[$];
   reg  [1:0]  bq[$];
   integer     errors = 0, samples_checked = 0, cyc = 0, t0 = 0, tl = -1, dur = 0, i;
   wire        awready, wready, bvalid, arready, rvalid, c_cl, c_op, frz, ll;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   localparam [159:0] MSK = {`RTS_M_SCALE, `RTS_M_AUX, `RTS_M_SHOT, `RTS_M_SEL, `RTS_M_CTRL};
   localparam [33:0]  ALL = {2'h3, 32'hffffffff};
   rts_sequencer #(.TICK_CYC(24'd10), .PULSE_CYC(25'd4), .HOUR_TICKS(13'd20)) dut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .breaker_closed_contact(c_cl), .breaker_open_contact(c_op),
      .delayed_first_shot_input(dly_in), .mode_select_switch(mode_sw),
      .watchdog_restart(wdog), .shot_pending_lamp(), .rearm_lamp(), .inst_lamp(),
      .lockout_lamp(ll), .pause_lamp(), .spare_lamp(), .pu_do_lamp(), .shot_num_lamps(),
      .disp_value(), .relays_frozen(frz), .fail_code());
   rts_breaker_model brk (.aclk(aclk), .close_cmd(close_cmd),
      .breaker_closed_contact(c_cl), .breaker_open_contact(c_op));
   initial forever #25 aclk = ~aclk;
   // --------------------
   // checks and bus tasks
   // --------------------
   task chk(input string nm, input [33:0] e, input [33:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // lamps blink per tick, so times are judged to within two ticks
   task near(input string nm, input integer e, input integer g);
      chk(nm, e, (g > e - 20 && g < e + 20) ? e : g);
   endtask
   task conclude;
      begin
         $display("errors %0d samples_checked %0d", errors, samples_checked);
         if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] dt, input [3:0] s, input [1:0] r);
      begin
         bq.push_back(r);
         awaddr <= a;
         wdata <= dt;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do @(posedge aclk); while (!awready);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         do @(posedge aclk); while (!bvalid);
         bready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task rd(input [7:0] a, input [33:0] e, input [33:0] mk, output [31:0] q);
      begin
         eq.push_back(e);
         mq.push_back(mk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge aclk); while (!arready);
         arvalid <= 1'b0;
         do @(posedge aclk); while (!rvalid);
         q = rdata;
         rready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task run(input [31:0] ctl, sc, input cl, dl, input integer ed, et);
      begin
         wr(`RTS_A_SCALE, sc, 4'hf, `RTS_RESP_OK);
         close_cmd <= cl;
         dly_in <= dl;
         repeat (30) @(posedge aclk);
         fin = 1'b0;
         wr(`RTS_A_CTRL, ctl & 32'h0c, 4'h1, `RTS_RESP_OK);
         wr(`RTS_A_CTRL, ctl, 4'h1, `RTS_RESP_OK);
         repeat (100) @(posedge aclk);
         ce <= 1'b0;
         repeat (5) @(posedge aclk);
         ce <= 1'b1;
         while (!fin) @(posedge aclk);
         near("test length", ed + 5, dur);
         near("lockout entry", et, tl);
      end
   endtask
   task readout(input [31:0] sel, aux, input integer e);
      integer ts;
      begin
         wr(`RTS_A_SEL, sel, 4'hf, `RTS_RESP_OK);
         wr(`RTS_A_AUX, aux, 4'hf, `RTS_RESP_OK);
         wr(`RTS_A_CTRL, 32'h01, 4'h1, `RTS_RESP_OK);
         ts = cyc;
         v = 32'h80;
         while (v[7]) rd(`RTS_A_STAT, 34'h0, 34'h0, v);
         near("readout length", e, cyc - ts);
      end
   endtask
   // answers are matched in issue order against the noted expectations
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (bvalid && bready)
         chk("bresp", bq.pop_front(), bresp);
      if (rvalid && rready) begin
         m = mq.pop_front();
         chk("rdata", eq.pop_front() & m, {rresp, rdata} & m);
      end
      if (frz && !fq) begin
         t0 = cyc;
         tl = -1;
      end
      if (ll && tl < 0)
         tl = cyc - t0;
      if (!frz && fq) begin
         dur = cyc - t0;
         fin = 1'b1;
      end
      fq = frz;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors = errors + 1;
      conclude;
   end
   initial begin
      v = $urandom(21877);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 7; i = i + 1)
         rd(8'(i * 4), (i == 4 || i == 5) ? 34'h1 : 34'h0, ALL, v);
      rd(8'h1c, {`RTS_RESP_DEC, 32'h0}, {2'h3, 32'h0}, v);
      wr(8'h1c, 32'hffffffff, 4'hf, `RTS_RESP_DEC);
      for (i = 0; i < 5; i = i + 1) begin
         d = $urandom & ((i == 0) ? 32'h0000000c : 32'hffffffff);
         wr(8'(i * 4), d, 4'hf, `RTS_RESP_OK);
         rd(8'(i * 4), {2'h0, d & MSK[i*32 +: 32]}, ALL, v);
      end
      wr(`RTS_A_AUX, 32'h0, 4'hf, `RTS_RESP_OK);
      wr(`RTS_A_AUX, 32'hffffffff, 4'h5, `RTS_RESP_OK);
      rd(`RTS_A_AUX, {2'h0, 32'h00ff00ff}, ALL, v);
      for (i = 0; i < 3; i = i + 1) begin
         mode_sw <= ~mode_sw;
         repeat (20) @(posedge aclk);
         rd(`RTS_A_FAULT, {2'h0, 31'h0, i == 2}, {2'h3, 32'hff}, v);
      end
      wr(`RTS_A_CTRL, 32'h10, 4'h1, `RTS_RESP_OK);
      rd(`RTS_A_FAULT, 34'h0, {2'h3, 32'hff}, v);
      wdog <= 1'b1;
      @(posedge aclk);
      wdog <= 1'b0;
      rd(`RTS_A_FAULT, 34'h1, {2'h3, 32'hff}, v);
      wr(`RTS_A_CTRL, 32'h10, 4'h1, `RTS_RESP_OK);
      wr(`RTS_A_SEL, 32'h0e, 4'hf, `RTS_RESP_OK);
      wr(`RTS_A_SHOT, 32'h080604, 4'hf, `RTS_RESP_OK);
      wr(`RTS_A_AUX, 32'h04, 4'hf, `RTS_RESP_OK);
      wr(`RTS_A_CTRL, 32'h02, 4'h1, `RTS_RESP_OK);
      rd(`RTS_A_STAT, 34'h1, {2'h3, 32'h7f}, v);
      run(32'h0a, 32'h1, 1'b1, 1'b0, 345, 245);
      run(32'h0e, 32'h1, 1'b1, 1'b0, 295, 195);
      run(32'h0a, 32'h1, 1'b1, 1'b1, 295, 195);
      run(32'h0a, 32'h2, 1'b1, 1'b0, 565, 425);
      run(32'h0a, 32'h1, 1'b0, 1'b0, 345, 5);
      readout(32'h0e, 32'h04, 400);
      readout(32'h0e, 32'h01010104, 640);
      readout(32'h02, 32'h04, 240);
      conclude;
   end
endmodule
